// ==== logic/pin_select_pkg.sv ====
// Package: register map, field layout and reset values of the port A/B pin function select block
package pin_select_pkg;
    localparam int unsigned ADDR_WIDTH = 4;
    localparam int unsigned DATA_WIDTH = 32;
    localparam int unsigned REG_WIDTH  = 16;

    localparam logic [ADDR_WIDTH-1:0] PORT_A_HIGH_DIRECTION_OFFSET    = 4'h0;
    localparam logic [ADDR_WIDTH-1:0] PORT_A_HIGH_FUNCTION_ONE_OFFSET = 4'h4;
    localparam logic [ADDR_WIDTH-1:0] PORT_A_HIGH_FUNCTION_TWO_OFFSET = 4'h8;
    localparam logic [ADDR_WIDTH-1:0] PORT_B_LOW_DIRECTION_OFFSET     = 4'hc;

    // Writable bits of each register; reserved bits are held at zero
    localparam logic [15:0] PORT_A_HIGH_DIRECTION_MASK    = 16'h03ff;
    localparam logic [15:0] PORT_A_HIGH_FUNCTION_ONE_MASK = 16'h0005;
    localparam logic [15:0] PORT_A_HIGH_FUNCTION_TWO_MASK = 16'h5555;
    localparam logic [15:0] PORT_B_LOW_DIRECTION_MASK     = 16'h3fff;

    localparam logic [15:0] PORT_A_HIGH_DIRECTION_RESET    = 16'h0000;
    localparam logic [15:0] PORT_A_HIGH_FUNCTION_ONE_RESET = 16'h0000;
    localparam logic [15:0] PORT_A_HIGH_FUNCTION_TWO_RESET = 16'h0000;
    localparam logic [15:0] PORT_B_LOW_DIRECTION_RESET     = 16'h0000;

    // Field positions of the pin 25 and pin 24 function bits
    localparam int unsigned PORTA_BIT25_FUNCTION_POS = 2;
    localparam int unsigned PORTA_BIT24_FUNCTION_POS = 0;

    localparam int unsigned PORT_A_PIN_COUNT = 10;
    localparam int unsigned PORT_A_PIN_BASE  = 16;
    localparam int unsigned PORT_B_PIN_COUNT = 14;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== logic/pin_select.sv ====
// Pin function and direction select for port A pins 25..16 and port B pins 13..0
//
// Notes on behaviour
// - Port A direction bits 9..0 set pins 25..16; 1 output, 0 input.
// - Port A direction applies only while the pin is general I/O.
// - Port A direction bits 15..10 read zero; software writes zero.
// - Port A direction register resets to all zeros, pins start as inputs.
// - Function one bit 2 picks pin 25: port I/O or address line 25.
// - Function one bit 0 picks pin 24: port I/O or address line 24.
// - Function one bits 15..3 and 1 read zero; software writes zero.
// - Function two even bits 14..0 pick pins 23..16: port or address line.
// - Function two odd bits read zero; software writes zero.
// - All port A function fields reset to zero, pins start as port I/O.
// - Port B direction bits 13..0 set pins 13..0; 1 output, 0 input.
// - Port B direction applies only while the pin is general I/O.
// - Port B direction bits 15 and 14 read zero; software writes zero.
// - Port B direction register resets to all zeros, pins start as inputs.
// - All four registers are 16 bits wide, readable and writable.
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module pin_select (
    input  wire logic                                   mclk_i,
    input  wire logic                                   rst_b_i,
    // AXI4-Lite slave
    input  wire logic [pin_select_pkg::ADDR_WIDTH-1:0]  s_axi_awaddr_i,
    input  wire logic                                   s_axi_awvalid_i,
    output logic                                        s_axi_awready_o,
    input  wire logic [pin_select_pkg::DATA_WIDTH-1:0]  s_axi_wdata_i,
    input  wire logic [3:0]                             s_axi_wstrb_i,
    input  wire logic                                   s_axi_wvalid_i,
    output logic                                        s_axi_wready_o,
    output logic [1:0]                                  s_axi_bresp_o,
    output logic                                        s_axi_bvalid_o,
    input  wire logic                                   s_axi_bready_i,
    input  wire logic [pin_select_pkg::ADDR_WIDTH-1:0]  s_axi_araddr_i,
    input  wire logic                                   s_axi_arvalid_i,
    output logic                                        s_axi_arready_o,
    output logic [pin_select_pkg::DATA_WIDTH-1:0]       s_axi_rdata_o,
    output logic [1:0]                                  s_axi_rresp_o,
    output logic                                        s_axi_rvalid_o,
    input  wire logic                                   s_axi_rready_i,
    // Port A pins 25..16 (index 0 is pin 16)
    input  wire logic [9:0]                             port_a_out_i,
    input  wire logic [9:0]                             address_line_i,
    output logic [9:0]                                  port_a_pin_o,
    output logic [9:0]                                  port_a_pin_oe_o,
    output logic [9:0]                                  port_a_function_o,
    // Port B pins 13..0, with per-pin alternate function request
    input  wire logic [13:0]                            port_b_out_i,
    input  wire logic [13:0]                            port_b_alt_select_i,
    input  wire logic [13:0]                            port_b_alt_out_i,
    input  wire logic [13:0]                            port_b_alt_oe_i,
    output logic [13:0]                                 port_b_pin_o,
    output logic [13:0]                                 port_b_pin_oe_o
);
    import pin_select_pkg::*;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_held;
        logic        w_held;
        logic [ADDR_WIDTH-1:0] aw_addr;
        logic [15:0] w_data;
        logic [1:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [15:0] port_a_high_direction;
        logic [15:0] port_a_high_function_one;
        logic [15:0] port_a_high_function_two;
        logic [15:0] port_b_low_direction;
        logic [9:0]  pa_pin;
        logic [9:0]  pa_oe;
        logic [9:0]  pa_func;
        logic [13:0] pb_pin;
        logic [13:0] pb_oe;
    } state_type;

    localparam state_type STATE_RESET = '{
        awready                  : 1'b1,
        wready                   : 1'b1,
        aw_held                  : 1'b0,
        w_held                   : 1'b0,
        aw_addr                  : '0,
        w_data                   : 16'h0000,
        w_strb                   : 2'b00,
        bvalid                   : 1'b0,
        bresp                    : RESP_OKAY,
        arready                  : 1'b1,
        rvalid                   : 1'b0,
        rdata                    : 32'h0000_0000,
        rresp                    : RESP_OKAY,
        port_a_high_direction    : PORT_A_HIGH_DIRECTION_RESET,
        port_a_high_function_one : PORT_A_HIGH_FUNCTION_ONE_RESET,
        port_a_high_function_two : PORT_A_HIGH_FUNCTION_TWO_RESET,
        port_b_low_direction     : PORT_B_LOW_DIRECTION_RESET,
        pa_pin                   : 10'h000,
        pa_oe                    : 10'h000,
        pa_func                  : 10'h000,
        pb_pin                   : 14'h0000,
        pb_oe                    : 14'h0000
    };

    state_type s_q;
    state_type s_d;

    // Function select per port A pin, index 0 is pin 16
    wire logic [9:0]  pa_func_sel;
    // Next pin value and enable per pin, from the registered selects
    wire logic [9:0]  pa_pin_next;
    wire logic [9:0]  pa_oe_next;
    wire logic [13:0] pb_pin_next;
    wire logic [13:0] pb_oe_next;

    assign pa_func_sel[9] = s_q.port_a_high_function_one[PORTA_BIT25_FUNCTION_POS];
    assign pa_func_sel[8] = s_q.port_a_high_function_one[PORTA_BIT24_FUNCTION_POS];

    // Pins 23..16 take the even bits of function two, pin 16 at bit 0
    for (genvar g = 0; g < 8; g++) begin : g_func_two
        assign pa_func_sel[g] = s_q.port_a_high_function_two[2*g];
    end

    // Address function drives the pin whatever its direction bit holds
    for (genvar g = 0; g < PORT_A_PIN_COUNT; g++) begin : g_port_a
        assign pa_pin_next[g] = pa_func_sel[g] ? address_line_i[g] : port_a_out_i[g];
        assign pa_oe_next[g]  = pa_func_sel[g] | s_q.port_a_high_direction[g];
    end

    // Another function takes over pin and enable; the direction bit is then ignored
    for (genvar g = 0; g < PORT_B_PIN_COUNT; g++) begin : g_port_b
        assign pb_pin_next[g] = port_b_alt_select_i[g] ? port_b_alt_out_i[g] : port_b_out_i[g];
        assign pb_oe_next[g]  = port_b_alt_select_i[g] ? port_b_alt_oe_i[g]
                                                       : s_q.port_b_low_direction[g];
    end

    function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [1:0] strb, input logic [15:0] mask);
        logic [15:0] m;
        m = {{8{strb[1]}}, {8{strb[0]}}};
        merge = ((old_v & ~m) | (new_v & m)) & mask;
    endfunction

    always_comb begin
        logic        do_write;
        logic [15:0] rd;
        logic        rd_ok;
        s_d      = s_q;
        do_write = 1'b0;
        rd       = 16'h0000;
        rd_ok    = 1'b1;

        // Write address and data are taken in either order
        if (s_q.awready && s_axi_awvalid_i) begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = s_axi_awaddr_i;
            s_d.awready = 1'b0;
        end
        if (s_q.wready && s_axi_wvalid_i) begin
            s_d.w_held = 1'b1;
            s_d.w_data = s_axi_wdata_i[15:0];
            s_d.w_strb = s_axi_wstrb_i[1:0];
            s_d.wready = 1'b0;
        end
        if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
            do_write    = 1'b1;
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = RESP_OKAY;
        end
        if (do_write) begin
            case (s_q.aw_addr)
                PORT_A_HIGH_DIRECTION_OFFSET:
                    s_d.port_a_high_direction = merge(s_q.port_a_high_direction, s_q.w_data,
                                                      s_q.w_strb, PORT_A_HIGH_DIRECTION_MASK);
                PORT_A_HIGH_FUNCTION_ONE_OFFSET:
                    s_d.port_a_high_function_one = merge(s_q.port_a_high_function_one, s_q.w_data,
                                                         s_q.w_strb, PORT_A_HIGH_FUNCTION_ONE_MASK);
                PORT_A_HIGH_FUNCTION_TWO_OFFSET:
                    s_d.port_a_high_function_two = merge(s_q.port_a_high_function_two, s_q.w_data,
                                                         s_q.w_strb, PORT_A_HIGH_FUNCTION_TWO_MASK);
                PORT_B_LOW_DIRECTION_OFFSET:
                    s_d.port_b_low_direction = merge(s_q.port_b_low_direction, s_q.w_data,
                                                     s_q.w_strb, PORT_B_LOW_DIRECTION_MASK);
                default:
                    s_d.bresp = RESP_SLVERR;
            endcase
        end
        if (s_q.bvalid && s_axi_bready_i) begin
            s_d.bvalid  = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready  = 1'b1;
        end

        // Read path: one read at a time, answer one cycle after the address is taken
        if (s_q.arready && s_axi_arvalid_i) begin
            case (s_axi_araddr_i)
                PORT_A_HIGH_DIRECTION_OFFSET:    rd = s_q.port_a_high_direction;
                PORT_A_HIGH_FUNCTION_ONE_OFFSET: rd = s_q.port_a_high_function_one;
                PORT_A_HIGH_FUNCTION_TWO_OFFSET: rd = s_q.port_a_high_function_two;
                PORT_B_LOW_DIRECTION_OFFSET:     rd = s_q.port_b_low_direction;
                default:                         rd_ok = 1'b0;
            endcase
            s_d.rdata   = {16'h0000, rd};
            s_d.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
            s_d.rvalid  = 1'b1;
            s_d.arready = 1'b0;
        end
        if (s_q.rvalid && s_axi_rready_i) begin
            s_d.rvalid  = 1'b0;
            s_d.arready = 1'b1;
        end

        // Pin drive, from the registered selects
        s_d.pa_pin  = pa_pin_next;
        s_d.pa_oe   = pa_oe_next;
        s_d.pa_func = pa_func_sel;
        s_d.pb_pin  = pb_pin_next;
        s_d.pb_oe   = pb_oe_next;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready_o   = s_q.awready;
    assign s_axi_wready_o    = s_q.wready;
    assign s_axi_bvalid_o    = s_q.bvalid;
    assign s_axi_bresp_o     = s_q.bresp;
    assign s_axi_arready_o   = s_q.arready;
    assign s_axi_rvalid_o    = s_q.rvalid;
    assign s_axi_rdata_o     = s_q.rdata;
    assign s_axi_rresp_o     = s_q.rresp;
    assign port_a_pin_o      = s_q.pa_pin;
    assign port_a_pin_oe_o   = s_q.pa_oe;
    assign port_a_function_o = s_q.pa_func;
    assign port_b_pin_o      = s_q.pb_pin;
    assign port_b_pin_oe_o   = s_q.pb_oe;
endmodule // pin_select

// ==== tb/pin_select_chk.sv ====
// Checker for the pin select block: register bus timing and pin routing
`timescale 1ns/1ps
module pin_select_chk (
    input wire logic        mclk_i, rst_b_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o,
    input wire logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic [1:0]  s_axi_bresp_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [9:0]  port_a_out_i, address_line_i, port_a_pin_o, port_a_pin_oe_o, port_a_function_o,
    input wire logic [13:0] port_b_out_i, port_b_alt_select_i, port_b_alt_out_i, port_b_alt_oe_i, port_b_pin_o,
    input wire logic [13:0] port_b_pin_oe_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    sequence wr_take;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence rd_take;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    chk_write_answer: assert property (wr_take |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o)
        else $error("write response not two cycles after take");
    chk_read_answer: assert property (rd_take |=> s_axi_rvalid_o && !s_axi_arready_o)
        else $error("read data not one cycle after take");
    chk_resp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped before accepted");
    chk_read_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped before accepted");
    chk_read_upper: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
        else $error("read data above register width not zero");
    chk_addr_drive: assert property (((port_a_pin_o ^ $past(address_line_i)) & port_a_function_o) == 10'h000)
        else $error("address pin does not carry address line");
    chk_addr_enable: assert property ((port_a_pin_oe_o & port_a_function_o) == port_a_function_o)
        else $error("address pin not driven");
    chk_gpio_a: assert property ($past(rst_b_i) |->
        ((port_a_pin_o ^ $past(port_a_out_i)) & port_a_pin_oe_o & ~port_a_function_o) == 10'h000)
        else $error("port a output pin value wrong");
    chk_alt_b: assert property ($past(rst_b_i) |->
        ((port_b_pin_oe_o ^ $past(port_b_alt_oe_i)) & $past(port_b_alt_select_i)) == 14'h0000)
        else $error("port b alternate enable not followed");
    chk_gpio_b: assert property ($past(rst_b_i) |->
        ((port_b_pin_o ^ $past(port_b_out_i)) & port_b_pin_oe_o & ~$past(port_b_alt_select_i)) == 14'h0000)
        else $error("port b output pin value wrong");
endmodule // pin_select_chk

bind pin_select pin_select_chk i_chk (.*);

// ==== tb/addr_bus_model.sv ====
// Memory-side receiver: shows the address it sees on the port A pins
`timescale 1ns/1ps
module addr_bus_model (
    input  wire logic [9:0] pin_i,
    input  wire logic [9:0] oe_i,
    output logic [9:0]      addr_seen_o
);
    // Undriven lines are pulled low on the board
    assign addr_seen_o = pin_i & oe_i;
endmodule // addr_bus_model

// ==== tb/pin_select_test.sv ====
// Self-checking bench for the port A/B pin select block
`timescale 1ns/1ps
module pin_select_test;
    import pin_select_pkg::*;
    logic        mclk_i = 0, rst_b_i = 0, awvalid = 0, wvalid = 0, arvalid = 0, bready = 1, rready = 1;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [3:0]  awaddr = 0, araddr = 0, wstrb = 0, s;
    logic [31:0] wdata = 0, rdata, got, d;
    logic [1:0]  bresp, rresp, resp;
    logic [9:0]  a_out = 0, a_addr = 0, a_pin, a_oe, a_fn, seen, fn, eoe, epin;
    logic [13:0] b_out = 0, b_sel = 0, b_aout = 0, b_aoe = 0, b_pin, b_oe, bo, bp;
    logic [15:0] m [4], bm;
    logic [15:0] msk [4] = '{16'h03ff, 16'h0005, 16'h5555, 16'h3fff};
    int          fails = 0, n_compared = 0, seed = 32'h74e7, i, k, r;
    always #2 mclk_i = ~mclk_i;
    pin_select i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .port_a_out_i(a_out),
        .address_line_i(a_addr), .port_a_pin_o(a_pin), .port_a_pin_oe_o(a_oe), .port_a_function_o(a_fn),
        .port_b_out_i(b_out), .port_b_alt_select_i(b_sel), .port_b_alt_out_i(b_aout), .port_b_alt_oe_i(b_aoe),
        .port_b_pin_o(b_pin), .port_b_pin_oe_o(b_oe));
    addr_bus_model i_bus (.pin_i(a_pin), .oe_i(a_oe), .addr_seen_o(seen));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] dd, input logic [3:0] ss);
        int n = 0;
        awaddr <= a; wdata <= dd; wstrb <= ss; awvalid <= 1'b1; wvalid <= 1'b1;
        bready <= 1'($random(seed));
        do begin
            @(posedge mclk_i);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
        end while (!(bvalid === 1'b1 && bready === 1'b1) && n < 50);
        resp = bresp;
        if (n >= 50) begin
            $display("unexpected write_wait expected %0d seen %0d", 50, n);
            fails++;
        end
    endtask
    task automatic rd(input logic [3:0] a);
        int n = 0;
        araddr <= a; arvalid <= 1'b1;
        rready <= 1'($random(seed));
        do begin
            @(posedge mclk_i);
            n++;
            if (arready) arvalid <= 1'b0;
            if (rvalid === 1'b1 && rready !== 1'b1) rready <= 1'b1;
        end while (!(rvalid === 1'b1 && rready === 1'b1) && n < 50);
        got = rdata; resp = rresp;
        if (n >= 50) begin
            $display("unexpected read_wait expected %0d seen %0d", 50, n);
            fails++;
        end
    endtask
    // Random pin inputs, then compare routing against the register model
    task automatic pins();
        a_out <= 10'($random(seed)); a_addr <= 10'($random(seed)); b_out <= 14'($random(seed));
        b_sel <= 14'($random(seed)); b_aout <= 14'($random(seed)); b_aoe <= 14'($random(seed));
        repeat (2) @(posedge mclk_i);
        for (k = 0; k < 10; k++) fn[k] = k < 8 ? m[2][2*k] : m[1][k == 8 ? 0 : 2];
        eoe = fn | m[0][9:0];
        epin = ((fn & a_addr) | (~fn & a_out)) & eoe;
        bo = (b_sel & b_aoe) | (~b_sel & m[3][13:0]);
        bp = ((b_sel & b_aout) | (~b_sel & b_out)) & bo;
        chk("a_function", fn, a_fn);
        chk("a_enable", eoe, a_oe);
        chk("a_pins", epin, a_pin & eoe);
        chk("bus_address", fn & a_addr, seen & fn);
        chk("b_enable", bo, b_oe);
        chk("b_pins", bp, b_pin & bo);
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        @(posedge mclk_i);
        for (i = 0; i < 4; i++) begin
            m[i] = 16'h0000;
            rd({i[1:0], 2'b00});
            chk("reset_value", 32'h0, got);
        end
        pins();
        for (i = 0; i < 60; i++) begin
            r = {$random(seed)} % 4;
            d = $random(seed);
            s = 4'($random(seed));
            wr({r[1:0], 2'b00}, d, s);
            chk("write_resp", RESP_OKAY, resp);
            bm = {{8{s[1]}}, {8{s[0]}}};
            m[r] = ((m[r] & ~bm) | (d[15:0] & bm)) & msk[r];
            rd({r[1:0], 2'b00});
            chk("read_back", m[r], got);
            pins();
        end
        // Reset in mid-run must bring every register and pin back to its start state
        rst_b_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        @(posedge mclk_i);
        for (i = 0; i < 4; i++) begin
            m[i] = 16'h0000;
            rd({i[1:0], 2'b00});
            chk("reset_again", 32'h0, got);
        end
        pins();
        wr(4'h6, 32'h0000ffff, 4'hf);
        chk("unmapped_write", RESP_SLVERR, resp);
        rd(4'h6);
        chk("unmapped_read", 32'h0, got);
        chk("unmapped_rresp", 32'(RESP_SLVERR), 32'(resp));
        report_and_stop();
    end
    initial begin
        #20000;
        fails++;
        report_and_stop();
    end
endmodule // pin_select_test
